// ===== design/dtco_timer.sv
/*
  dtco_timer: two 8-bit timers in independent mode, timer b square
  wave, carrier output gating from a reloaded data bit, port 6 pins.
  Assumes clk is the main system clock and the host writes whole bytes.
*/
// Summary of operation
// [RULE1] output control register resets to zero; byte writes only
// [RULE2] with data bit 1, select 0 gives carrier, select 1 gives high
// [RULE3] each rising timer a match copies buffer bit into data bit
// [RULE4] data bit 0 drives output low and stops the carrier clock
// [RULE5] software writes zero to control bits 3 to 7
// [RULE6] software updates the control register with byte writes only
// [RULE7] data bit writes ignored while timer b output is enabled
// [RULE8] buffer bit is lost on stop; software rewrites before restart
// [RULE9] software loads compares and data bits before carrier operation
// [RULE10] direction register resets to ones; 0 output, 1 input
// [RULE11] software clears direction and latch to route timer b out
// [RULE12] compare match clears counter, counting goes on, interrupt fires
// [RULE13] software follows the interval timer setup order
// [RULE14] software stops a timer before changing its clock select
// [RULE15] timer a clock: fx/64, fx/256, b match, b carrier clock
// [RULE16] timer b clock: fx/1, /4, /2, /4, /8, /16
// [RULE17] only timer b has square wave; timer a is interval only
// [RULE18] square wave: match toggles pin, clears counter, interrupts
// [RULE19] clearing b count enable forces output low; starts low
// [RULE20] square wave period is 2*(compare+1) count clock periods
// [RULE21] software follows the square wave setup order
// [RULE22] output is low at the moment output enable is set
// [RULE23] count enable 0 clears and stops counter; 1 starts it
// [RULE24] mode 000 is independent; output enable 0 leaves port mode
// [RULE25] counters clear after reset and on overflow
// [RULE26] match interrupt is a one-clock pulse at the clearing cycle
`timescale 1ns/1ps
module dtco_timer (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // register port
  input  wire logic [15:0] sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_wdata,
  output logic      [7:0]  sfr_rdata,
  // interrupts
  output logic             timer_a_match_interrupt,
  output logic             timer_b_match_interrupt,
  // port 6 pins, pin 0 shared with timer b output
  input  wire logic [1:0]  port6_pin_in,
  output logic      [1:0]  port6_pin_out,
  output logic      [1:0]  port6_pin_oe_n
);
  import dtco_pkg::*;

  logic [7:0] tmc_a_reg;
  logic [7:0] tmc_b_reg;
  logic [7:0] cmp_a_reg;
  logic [7:0] cmp_b_reg;
  logic [7:0] cnt_a_reg;
  logic [7:0] cnt_b_reg;
  logic [7:0] div_reg;
  logic [1:0] port6_dir_reg;
  logic [1:0] port6_lat_reg;
  logic       rsel_reg;
  logic       next_reg;
  logic       odata_reg;
  logic       tob_reg;
  logic       tob_prev_reg;

  function automatic logic pre_tick(input logic [7:0] d,
                                    input logic [3:0] sh);
    logic [7:0] mask;
    mask = 8'((9'h001 << sh) - 9'h001);
    return (d & mask) == mask;
  endfunction

  // decode
  wire wr_tmc_a = sfr_wr && sfr_addr == DTCO_ADDR_TMC_A;
  wire wr_tmc_b = sfr_wr && sfr_addr == DTCO_ADDR_TMC_B;
  wire wr_cmp_a = sfr_wr && sfr_addr == DTCO_ADDR_CMP_A;
  wire wr_cmp_b = sfr_wr && sfr_addr == DTCO_ADDR_CMP_B;
  wire wr_coc   = sfr_wr && sfr_addr == DTCO_ADDR_COC;
  wire wr_pdir  = sfr_wr && sfr_addr == DTCO_ADDR_PDIR6;
  wire wr_port  = sfr_wr && sfr_addr == DTCO_ADDR_PORT6;

  wire       tce_a  = tmc_a_reg[DTCO_TCE_BIT];
  wire       tce_b  = tmc_b_reg[DTCO_TCE_BIT];
  wire       toe_b  = tmc_b_reg[DTCO_TOE_BIT];
  wire [1:0] clk_a  = tmc_a_reg[DTCO_CLKA_LSB +: 2];
  wire [2:0] clk_b  = tmc_b_reg[DTCO_CLKB_LSB +: 3];
  wire [2:0] mode   = {tmc_a_reg[DTCO_MODEA_BIT],
                       tmc_b_reg[DTCO_MODEB_LSB +: 2]};
  wire       m_ind  = mode == DTCO_MODE_INDEP;  // see [RULE24]
  wire       m_car  = mode == DTCO_MODE_CARR;

  // timer b count clock
  wire tick_b = clk_b == 3'h0 ? pre_tick(div_reg, DTCO_SH_B0) : // see [RULE16]
                clk_b == 3'h1 ? pre_tick(div_reg, DTCO_SH_B1) :
                clk_b == 3'h2 ? pre_tick(div_reg, DTCO_SH_B2) :
                clk_b == 3'h3 ? pre_tick(div_reg, DTCO_SH_B3) :
                clk_b == 3'h4 ? pre_tick(div_reg, DTCO_SH_B4) :
                clk_b == 3'h5 ? pre_tick(div_reg, DTCO_SH_B5) : 1'b0;
  wire match_b = tce_b && tick_b && cnt_b_reg == cmp_b_reg;

  // carrier clock is the rising edge of timer b output, held while
  // the data bit is 0 in carrier mode
  wire car_clk = tob_reg && !tob_prev_reg &&
                 !(m_car && !odata_reg);               // see [RULE4]
  wire tick_a  = clk_a == 2'h0 ? pre_tick(div_reg, DTCO_SH_A0) : // see [RULE15]
                 clk_a == 2'h1 ? pre_tick(div_reg, DTCO_SH_A1) :
                 clk_a == 2'h2 ? timer_b_match_interrupt : car_clk;
  wire match_a = tce_a && tick_a && cnt_a_reg == cmp_a_reg;
  // match held across back-to-back ticks counts as one rising edge
  wire rise_a  = match_a && !timer_a_match_interrupt;   // see [RULE3]

  // timer b output level on the shared pin
  wire wave_on = toe_b && tce_b && (m_ind || m_car);    // see [RULE17]
  // the enabling write itself forces the output low
  wire toe_set = wr_tmc_b && sfr_wdata[DTCO_TOE_BIT] && !toe_b; // see [RULE22]
  wire tob_nxt = !tce_b ? 1'b0 :                        // see [RULE19]
                 toe_set ? 1'b0 :
                 (match_b && wave_on) ? !tob_reg : tob_reg; // see [RULE18]
  wire car_lvl = !odata_reg ? 1'b0 :                    // see [RULE4]
                 rsel_reg ? 1'b1 : tob_reg;             // see [RULE2]
  wire tmr_lvl = m_car ? car_lvl : tob_reg;
  wire pin0    = toe_b ? tmr_lvl : port6_lat_reg[0];    // see [RULE24]

  wire [7:0] rd_mux =
    sfr_addr == DTCO_ADDR_TMC_A ? tmc_a_reg :
    sfr_addr == DTCO_ADDR_TMC_B ? tmc_b_reg :
    sfr_addr == DTCO_ADDR_CMP_A ? cmp_a_reg :
    sfr_addr == DTCO_ADDR_CMP_B ? cmp_b_reg :
    sfr_addr == DTCO_ADDR_CNT_A ? cnt_a_reg :
    sfr_addr == DTCO_ADDR_CNT_B ? cnt_b_reg :
    sfr_addr == DTCO_ADDR_COC   ? {5'h00, rsel_reg, next_reg, odata_reg} :
    sfr_addr == DTCO_ADDR_PDIR6 ? {6'h3F, port6_dir_reg} :
    sfr_addr == DTCO_ADDR_PORT6 ? {6'h00, port6_pin_in} : 8'h00;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tmc_a_reg     <= DTCO_RST_TMC;
      tmc_b_reg     <= DTCO_RST_TMC;
      cmp_a_reg     <= DTCO_RST_CMP;
      cmp_b_reg     <= DTCO_RST_CMP;
      port6_dir_reg <= DTCO_RST_PDIR6[1:0];             // see [RULE10]
      port6_lat_reg <= DTCO_RST_PORT6[1:0];
    end else begin
      if (wr_tmc_a) tmc_a_reg <= sfr_wdata;
      if (wr_tmc_b) tmc_b_reg <= sfr_wdata;
      if (wr_cmp_a) cmp_a_reg <= sfr_wdata;
      if (wr_cmp_b) cmp_b_reg <= sfr_wdata;
      if (wr_pdir)  port6_dir_reg <= sfr_wdata[1:0];
      if (wr_port)  port6_lat_reg <= sfr_wdata[1:0];
    end
  end

  // counters: clear when stopped, on match, wrap on overflow
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_a_reg <= 8'h00;                               // see [RULE25]
      cnt_b_reg <= 8'h00;
    end else begin
      if (!tce_a || match_a) cnt_a_reg <= 8'h00;        // see [RULE12]
      else if (tick_a)       cnt_a_reg <= cnt_a_reg + 8'h01;
      if (!tce_b || match_b) cnt_b_reg <= 8'h00;        // see [RULE23]
      else if (tick_b)       cnt_b_reg <= cnt_b_reg + 8'h01;
    end
  end

  // carrier output control; the hardware reload beats a software write
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rsel_reg  <= DTCO_RST_COC[DTCO_RSEL_BIT];         // see [RULE1]
      next_reg  <= DTCO_RST_COC[DTCO_NEXT_BIT];
      odata_reg <= DTCO_RST_COC[DTCO_ODATA_BIT];
    end else begin
      if (wr_coc) begin
        rsel_reg <= sfr_wdata[DTCO_RSEL_BIT];
        next_reg <= sfr_wdata[DTCO_NEXT_BIT];
      end else if (wr_tmc_b && tce_b && !sfr_wdata[DTCO_TCE_BIT]) begin
        next_reg <= 1'b0;                               // see [RULE8]
      end
      if (rise_a)
        odata_reg <= next_reg;                          // see [RULE3]
      else if (wr_coc && !toe_b)
        odata_reg <= sfr_wdata[DTCO_ODATA_BIT];         // see [RULE7]
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tob_reg                 <= 1'b0;
      tob_prev_reg            <= 1'b0;
      timer_a_match_interrupt <= 1'b0;
      timer_b_match_interrupt <= 1'b0;
      port6_pin_out           <= 2'h0;
      port6_pin_oe_n          <= 2'h3;
      sfr_rdata               <= 8'h00;
    end else begin
      tob_reg                 <= tob_nxt;
      tob_prev_reg            <= tob_reg;
      timer_a_match_interrupt <= match_a;               // see [RULE26]
      timer_b_match_interrupt <= match_b;
      port6_pin_out           <= {port6_lat_reg[1], pin0};
      port6_pin_oe_n          <= port6_dir_reg;         // see [RULE10]
      if (sfr_rd) sfr_rdata   <= rd_mux;
    end
  end

  // helper: cycles since the last timer b match; armed only after a match
  // with an unchanged setup, so the first period after a restart is skipped
  logic [15:0] half_cnt_reg;
  logic        half_arm_reg;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      half_cnt_reg <= 16'h0000;
      half_arm_reg <= 1'b0;
    end else begin
      if (match_b)
        half_cnt_reg <= 16'h0001;
      else if (half_cnt_reg != 16'hFFFF)
        half_cnt_reg <= half_cnt_reg + 16'h0001;
      if (!wave_on || wr_tmc_b || wr_cmp_b)
        half_arm_reg <= 1'b0;
      else if (match_b)
        half_arm_reg <= 1'b1;
    end
  end

  // each check looks one edge after its cause, except a_irq_b_pulse, a_oe_follows_dir, a_enable_low and a_half_period, which check in the same cycle
  a_match_clears_a: assert property ( // see [RULE12]
    @(posedge clk) disable iff (!reset_n)
    match_a |=> cnt_a_reg == 8'h00 && timer_a_match_interrupt)
    else $error("timer a match did not clear counter");
  a_match_clears_b: assert property ( // see [RULE18]
    @(posedge clk) disable iff (!reset_n)
    match_b |=> cnt_b_reg == 8'h00 && timer_b_match_interrupt)
    else $error("timer b match did not clear counter");
  a_irq_b_pulse: assert property ( // see [RULE26]
    @(posedge clk) disable iff (!reset_n)
    timer_b_match_interrupt |-> $past(cnt_b_reg) == $past(cmp_b_reg))
    else $error("timer b interrupt without match");
  a_reload_data: assert property ( // see [RULE3]
    @(posedge clk) disable iff (!reset_n)
    rise_a |=> odata_reg == $past(next_reg))
    else $error("data bit not reloaded on timer a match");
  a_data_locked: assert property ( // see [RULE7]
    @(posedge clk) disable iff (!reset_n)
    (toe_b && !rise_a) |=> $stable(odata_reg))
    else $error("data bit changed while output enabled");
  a_buffer_lost: assert property ( // see [RULE8]
    @(posedge clk) disable iff (!reset_n)
    (wr_tmc_b && tce_b && !sfr_wdata[DTCO_TCE_BIT]) |=> !next_reg)
    else $error("buffer bit kept across a stop");
  a_stop_clears: assert property ( // see [RULE19]
    @(posedge clk) disable iff (!reset_n)
    !tce_b |=> cnt_b_reg == 8'h00 && !tob_reg)
    else $error("timer b stop did not clear count and output");
  a_carrier_low: assert property ( // see [RULE4]
    @(posedge clk) disable iff (!reset_n)
    (toe_b && m_car && !odata_reg) |=> !port6_pin_out[0])
    else $error("pin not low with data bit zero");
  a_remote_high: assert property ( // see [RULE2]
    @(posedge clk) disable iff (!reset_n)
    (toe_b && m_car && odata_reg && rsel_reg) |=> port6_pin_out[0])
    else $error("pin not high in remote high mode");
  a_remote_pulse: assert property ( // see [RULE2]
    @(posedge clk) disable iff (!reset_n)
    (toe_b && m_car && odata_reg && !rsel_reg)
    |=> port6_pin_out[0] == $past(tob_reg))
    else $error("pin does not follow the carrier pulse");
  a_port_mode: assert property ( // see [RULE24]
    @(posedge clk) disable iff (!reset_n)
    !toe_b |=> port6_pin_out[0] == $past(port6_lat_reg[0]))
    else $error("pin 0 not driven from the latch in port mode");
  a_oe_follows_dir: assert property ( // see [RULE10]
    @(posedge clk) disable iff (!reset_n)
    port6_pin_oe_n == $past(port6_dir_reg))
    else $error("output enables do not follow the direction bits");
  a_toggle_match: assert property ( // see [RULE18]
    @(posedge clk) disable iff (!reset_n)
    (match_b && wave_on && !wr_tmc_b) |=> tob_reg != $past(tob_reg))
    else $error("square wave did not toggle on match");
  a_enable_low: assert property ( // see [RULE22]
    @(posedge clk) disable iff (!reset_n)
    $rose(toe_b) |-> !tob_reg)
    else $error("output not low when output enabled");
  a_tick_b_rate: assert property ( // see [RULE16]
    @(posedge clk) disable iff (!reset_n)
    (tce_b && clk_b == 3'h1 && div_reg[1:0] != 2'h3) |=> $stable(cnt_b_reg))
    else $error("timer b counted off its quarter rate tick");
  a_tick_a_rate: assert property ( // see [RULE15]
    @(posedge clk) disable iff (!reset_n)
    (tce_a && clk_a == 2'h0 && div_reg[5:0] != 6'h3F) |=> $stable(cnt_a_reg))
    else $error("timer a counted off its slow tick");
  a_half_period: assert property ( // see [RULE20]
    @(posedge clk) disable iff (!reset_n)
    (match_b && wave_on && clk_b == 3'h0 && half_arm_reg)
    |-> half_cnt_reg == {8'h00, cmp_b_reg} + 16'h0001)
    else $error("square wave half period wrong");
endmodule

// ===== design/dtco_pkg.sv
/*
  dtco_pkg: addresses, field positions, reset values and prescaler
  shifts for the dual 8-bit timer with carrier output control.
  Assumes a byte-wide special-function-register port on the host side.
*/
package dtco_pkg;
  // register addresses
  localparam logic [15:0] DTCO_ADDR_CNT_A  = 16'hFF62;
  localparam logic [15:0] DTCO_ADDR_CNT_B  = 16'hFF63;
  localparam logic [15:0] DTCO_ADDR_TMC_A  = 16'hFF65;
  localparam logic [15:0] DTCO_ADDR_CMP_A  = 16'hFF66;
  localparam logic [15:0] DTCO_ADDR_CMP_B  = 16'hFF67;
  localparam logic [15:0] DTCO_ADDR_TMC_B  = 16'hFF69;
  localparam logic [15:0] DTCO_ADDR_COC    = 16'hFF6A;
  localparam logic [15:0] DTCO_ADDR_PORT6  = 16'hFF06;
  localparam logic [15:0] DTCO_ADDR_PDIR6  = 16'hFF26;
  // reset values
  localparam logic [7:0]  DTCO_RST_TMC     = 8'h00;
  localparam logic [7:0]  DTCO_RST_COC     = 8'h00;
  localparam logic [7:0]  DTCO_RST_PDIR6   = 8'hFF;
  localparam logic [7:0]  DTCO_RST_PORT6   = 8'h00;
  localparam logic [7:0]  DTCO_RST_CMP     = 8'h00;
  // field positions, both mode control registers
  localparam int          DTCO_TCE_BIT     = 7;
  localparam int          DTCO_TOE_BIT     = 0;
  localparam int          DTCO_CLKB_LSB    = 3;
  localparam int          DTCO_CLKA_LSB    = 3;
  localparam int          DTCO_MODEA_BIT   = 1;
  localparam int          DTCO_MODEB_LSB   = 1;
  // carrier output control fields
  localparam int          DTCO_ODATA_BIT   = 0;
  localparam int          DTCO_NEXT_BIT    = 1;
  localparam int          DTCO_RSEL_BIT    = 2;
  // mode codes {timer a bit, timer b two bits}
  localparam logic [2:0]  DTCO_MODE_INDEP  = 3'h0;
  localparam logic [2:0]  DTCO_MODE_CARR   = 3'h3;
  // prescaler shifts of the main clock
  localparam logic [3:0]  DTCO_SH_A0       = 4'h6;
  localparam logic [3:0]  DTCO_SH_A1       = 4'h8;
  localparam logic [3:0]  DTCO_SH_B0       = 4'h0;
  localparam logic [3:0]  DTCO_SH_B1       = 4'h2;
  localparam logic [3:0]  DTCO_SH_B2       = 4'h1;
  localparam logic [3:0]  DTCO_SH_B3       = 4'h2;
  localparam logic [3:0]  DTCO_SH_B4       = 4'h3;
  localparam logic [3:0]  DTCO_SH_B5       = 4'h4;
endpackage

// ===== verif/dtco_timer_bench.sv
/*
  dtco_timer_bench: self-checking bench for the dual 8-bit timer with
  carrier output control, driven through the byte-wide register port.
  Assumes dtco_pkg is compiled first and a 10 MHz main clock.
*/
`timescale 1ns/1ps
module dtco_timer_bench;
  import dtco_pkg::*;
  logic        clk       = 1'b0;
  logic        reset_n   = 1'b0;
  logic [15:0] sfr_addr  = 16'h0000;
  logic        sfr_wr    = 1'b0;
  logic        sfr_rd    = 1'b0;
  logic [7:0]  sfr_wdata = 8'h00;
  logic [7:0]  sfr_rdata;
  logic        irq_a;
  logic        irq_b;
  logic [1:0]  pin_in    = 2'h2;
  logic [1:0]  pin_out;
  logic [1:0]  pin_oe_n;
  int          num_errors = 0;
  int          tests_run  = 0;
  int          cycles     = 0;
  int          n;

  dtco_timer dut (
    .clk                     (clk),
    .reset_n                 (reset_n),
    .sfr_addr                (sfr_addr),
    .sfr_wr                  (sfr_wr),
    .sfr_rd                  (sfr_rd),
    .sfr_wdata               (sfr_wdata),
    .sfr_rdata               (sfr_rdata),
    .timer_a_match_interrupt (irq_a),
    .timer_b_match_interrupt (irq_b),
    .port6_pin_in            (pin_in),
    .port6_pin_out           (pin_out),
    .port6_pin_oe_n          (pin_oe_n)
  );

  always #50 clk = ~clk;

  // ceiling well above the slowest prescaler runs below
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      num_errors++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // strobe raised one edge after the previous one dropped, never same step
  task automatic wr(logic [15:0] a, logic [7:0] d);
    @(posedge clk);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge clk);
    sfr_wr    <= 1'b0;
  endtask

  task automatic rd_chk(string name, logic [15:0] a, logic [7:0] e);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rd   <= 1'b1;
    @(posedge clk);
    sfr_rd   <= 1'b0;
    @(posedge clk);
    check(name, sfr_rdata, e);
  endtask

  function automatic bit hit(int kind, logic prev);
    if (kind == 0) return irq_a === 1'b1;
    if (kind == 1) return irq_b === 1'b1;
    return pin_out[0] !== prev;
  endfunction

  // the first two events only align, the third gap is the one reported;
  // a mode change on the pin may make a short first gap
  task automatic measure(int kind, output int gap);
    logic prev;
    int   i;
    prev = pin_out[0];
    for (i = 0; i < 3; i++) begin
      gap = 0;
      do begin
        @(posedge clk);
        gap++;
      end while (!hit(kind, prev) && gap < 3000);
      prev = pin_out[0];
    end
  endtask

  task automatic t_reset();
    check("oe_n at reset", {6'h0, pin_oe_n}, 8'h03);
    rd_chk("control reset", DTCO_ADDR_COC, 8'h00);
    rd_chk("direction reset", DTCO_ADDR_PDIR6, 8'hFF);
    rd_chk("counter b reset", DTCO_ADDR_CNT_B, 8'h00);
  endtask

  task automatic t_regs();
    wr(DTCO_ADDR_COC, 8'h07);
    rd_chk("control bits", DTCO_ADDR_COC, 8'h07);
    wr(DTCO_ADDR_COC, 8'h00);
    rd_chk("control cleared", DTCO_ADDR_COC, 8'h00);
    wr(DTCO_ADDR_PDIR6, 8'hFE);
    wr(DTCO_ADDR_PORT6, 8'h02);
    repeat (2) @(posedge clk);
    check("oe_n pin0 out", {6'h0, pin_oe_n}, 8'h02);
    check("latch on pins", {6'h0, pin_out}, 8'h02);
    rd_chk("port 6 pins", DTCO_ADDR_PORT6, 8'h02);
  endtask

  task automatic t_timer_b();
    int sh[6] = '{0, 2, 1, 2, 3, 4};
    int c;
    wr(DTCO_ADDR_CMP_B, 8'h01);
    for (c = 0; c < 6; c++) begin
      wr(DTCO_ADDR_TMC_B, 8'h00);
      wr(DTCO_ADDR_TMC_B, 8'h80 | 8'(c << 3));
      measure(1, n);
      check("timer b interval", 8'(n), 8'(2 << sh[c]));
    end
    // compare 0 at full rate: the counter never leaves zero
    wr(DTCO_ADDR_TMC_B, 8'h00);
    wr(DTCO_ADDR_CMP_B, 8'h00);
    wr(DTCO_ADDR_TMC_B, 8'h80);
    measure(1, n);
    check("timer b cmp zero", 8'(n), 8'h01);
  endtask

  task automatic t_timer_a();
    wr(DTCO_ADDR_CMP_A, 8'h01);
    wr(DTCO_ADDR_TMC_A, 8'h80);
    measure(0, n);
    check("timer a div64", 8'(n >> 7), 8'h01);
    wr(DTCO_ADDR_TMC_A, 8'h00);
    rd_chk("counter a stop", DTCO_ADDR_CNT_A, 8'h00);
    wr(DTCO_ADDR_TMC_A, 8'h88);
    measure(0, n);
    check("timer a div256", 8'(n >> 9), 8'h01);
    // timer b matches every 2 cycles drive timer a through code 2
    wr(DTCO_ADDR_TMC_A, 8'h00);
    wr(DTCO_ADDR_CMP_A, 8'h02);
    wr(DTCO_ADDR_TMC_B, 8'h00);
    wr(DTCO_ADDR_CMP_B, 8'h01);
    wr(DTCO_ADDR_TMC_B, 8'h80);
    wr(DTCO_ADDR_TMC_A, 8'h90);
    measure(0, n);
    check("timer a on b match", 8'(n), 8'h06);
    wr(DTCO_ADDR_TMC_A, 8'h00);
  endtask

  task automatic t_square();
    wr(DTCO_ADDR_TMC_B, 8'h00);
    wr(DTCO_ADDR_TMC_B, 8'h11);
    wr(DTCO_ADDR_CMP_B, 8'h03);
    repeat (2) @(posedge clk);
    check("square start low", {7'h0, pin_out[0]}, 8'h00);
    wr(DTCO_ADDR_TMC_B, 8'h91);
    measure(2, n);
    check("square half period", 8'(n), 8'h08);
    wr(DTCO_ADDR_TMC_B, 8'h11);
    // output flop then pin flop: the low level shows two edges later
    repeat (3) @(posedge clk);
    check("square stop low", {7'h0, pin_out[0]}, 8'h00);
    rd_chk("counter b stop", DTCO_ADDR_CNT_B, 8'h00);
  endtask

  task automatic t_carrier();
    wr(DTCO_ADDR_TMC_B, 8'h00);
    wr(DTCO_ADDR_CMP_B, 8'h01);
    wr(DTCO_ADDR_CMP_A, 8'h02);
    wr(DTCO_ADDR_COC, 8'h01);
    wr(DTCO_ADDR_TMC_B, 8'h07);
    // data bit write is refused once the output is enabled
    wr(DTCO_ADDR_COC, 8'h04);
    rd_chk("data bit locked", DTCO_ADDR_COC, 8'h05);
    check("select high", {7'h0, pin_out[0]}, 8'h01);
    wr(DTCO_ADDR_TMC_B, 8'h87);
    wr(DTCO_ADDR_TMC_A, 8'h90);
    measure(0, n);
    rd_chk("reload zero", DTCO_ADDR_COC, 8'h04);
    check("data zero low", {7'h0, pin_out[0]}, 8'h00);
    wr(DTCO_ADDR_COC, 8'h06);
    measure(0, n);
    rd_chk("reload one", DTCO_ADDR_COC, 8'h07);
    check("data one high", {7'h0, pin_out[0]}, 8'h01);
    wr(DTCO_ADDR_COC, 8'h02);
    measure(2, n);
    check("carrier pulse", 8'(n), 8'h02);
    // stop timer a first so no reload lands after the stop
    wr(DTCO_ADDR_TMC_A, 8'h00);
    wr(DTCO_ADDR_TMC_B, 8'h07);
    rd_chk("buffer lost on stop", DTCO_ADDR_COC, 8'h01);
    check("carrier stop low", {7'h0, pin_out[0]}, 8'h00);
  endtask

  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_regs();
    t_timer_b();
    t_timer_a();
    t_square();
    t_carrier();
    final_report();
  end
endmodule
